// file: hdl/pecs_pkg.sv
// package: register map, field layout and state types of the pecs block
package pecs_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned IDLE_LOSS_US  = 1000;
    localparam int unsigned IDLE_LOSS_CYC = IDLE_LOSS_US * CLK_MHZ;
    localparam int unsigned IDLE_CNT_W    = 17;

    // ************************************************************
    // register indices, byte address is index times four
    // ************************************************************
    localparam int unsigned ADDR_W       = 12;
    localparam logic [7:0]  IDX_CTRL1    = 8'h10;
    localparam logic [7:0]  IDX_STAT1    = 8'h11;
    localparam logic [7:0]  IDX_CTRL2    = 8'h14;
    localparam logic [7:0]  IDX_RXERR    = 8'h15;
    localparam logic [7:0]  IDX_IRQ_STAT = 8'h18;
    localparam logic [7:0]  IDX_IRQ_MASK = 8'h19;
    localparam logic [7:0]  IDX_SWRST    = 8'h1a;

    // ************************************************************
    // reset values and fields
    // ************************************************************
    localparam logic [15:0] CTRL1_RST   = 16'h0078;
    localparam logic [15:0] CTRL2_RST   = 16'h0c68;
    localparam logic [15:0] CTRL2_WMASK = 16'h7fff;
    localparam logic [15:0] CTRL2_SWCLR = 16'h0007;
    localparam logic [15:0] RXERR_RST   = 16'h0000;
    localparam logic [15:0] RXERR_MAX   = 16'hffff;
    localparam int unsigned MDI_LSB     = 5;
    localparam int unsigned AN_EN_BIT   = 3;
    localparam int unsigned LOSS_BIT    = 15;
    localparam int unsigned SPD_LSB     = 14;
    localparam int unsigned DUP_BIT     = 13;
    localparam int unsigned PAGE_BIT    = 12;
    localparam int unsigned RES_BIT     = 11;
    localparam int unsigned LINK_BIT    = 10;
    localparam int unsigned CLEN_LSB    = 7;
    localparam int unsigned XOV_BIT     = 6;
    localparam int unsigned TXP_BIT     = 3;
    localparam int unsigned RXP_BIT     = 2;
    localparam int unsigned POL_BIT     = 1;
    localparam int unsigned JAB_BIT     = 0;
    localparam int unsigned SWRST_BIT   = 0;
    localparam logic [1:0]  MDI_STRAIGHT = 2'h0;
    localparam logic [1:0]  MDI_CROSSED  = 2'h1;
    localparam logic [1:0]  MDI_AUTO     = 2'h3;
    localparam logic [1:0]  SPEED_GIG    = 2'h2;
    localparam int unsigned IRQ_W    = 4;
    localparam int unsigned IRQ_PAGE = 0;
    localparam int unsigned IRQ_LOSS = 1;
    localparam int unsigned IRQ_JAB  = 2;
    localparam int unsigned IRQ_SAT  = 3;

    // ************************************************************
    // carriers and state
    // ************************************************************
    typedef struct packed {
        logic [1:0] speed;
        logic       duplex;
        logic       page;
        logic       an_done;
        logic       an_off;
        logic       link;
        logic [2:0] cable_len;
        logic       xover;
        logic       tx_pause;
        logic       rx_pause;
        logic       polarity;
        logic       jabber;
        logic       idle_seen;
        logic       rx_err;
    } pecs_phy_in_type;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } pecs_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pecs_apb_rsp_type;

    typedef struct packed {
        logic [15:0]           ctrl1;
        logic [15:0]           ctrl2;
        logic [15:0]           stat1;
        logic [1:0]            mdi_eff;
        logic                  an_en_eff;
        logic                  loss;
        logic [IDLE_CNT_W-1:0] idle_cnt;
        logic [IRQ_W-1:0]      irq_stat;
        logic [IRQ_W-1:0]      irq_mask;
        logic                  irq;
        logic                  jab_d;
        logic                  sat_d;
        logic                  swrst;
        pecs_apb_rsp_type      rsp;
    } pecs_state_type;

    typedef struct packed {
        logic [15:0] count;
    } pecs_cnt_state_type;

    localparam pecs_state_type STATE_RST = '{
        ctrl1: CTRL1_RST, ctrl2: CTRL2_RST, mdi_eff: MDI_AUTO,
        an_en_eff: 1'b1, default: '0};

endpackage : pecs_pkg

// file: hdl/pecs_err_counter.sv
// saturating receive error counter, cleared on read or soft reset
module pecs_err_counter (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // control
    input  wire logic        inc_i,
    input  wire logic        clr_i,
    // count
    output logic [15:0]      count_o,
    output logic             sat_o
);

    pecs_pkg::pecs_cnt_state_type s_reg;
    pecs_pkg::pecs_cnt_state_type s_next;

    // ************************************************************
    // counting
    // ************************************************************
    // an error arriving in the clearing cycle is kept as the first count
    always_comb begin
        s_next = s_reg;
        if (clr_i) begin
            s_next.count = inc_i ? 16'h0001 : pecs_pkg::RXERR_RST;
        end else if (inc_i && s_reg.count != pecs_pkg::RXERR_MAX) begin
            s_next.count = s_reg.count + 16'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_reg.count <= pecs_pkg::RXERR_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign count_o = s_reg.count;
    assign sat_o   = (s_reg.count == pecs_pkg::RXERR_MAX);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_cnt_inc;
        inc_i && !clr_i && !sat_o |=> count_o == $past(count_o) + 16'h0001;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc)
        else $error("error count did not advance");

    property p_cnt_sat;
        sat_o && !clr_i |=> sat_o;
    endproperty
    a_cnt_sat: assert property (p_cnt_sat)
        else $error("error count wrapped past all ones");

    property p_cnt_clr;
        clr_i |=> count_o == {15'h0000, $past(inc_i)};
    endproperty
    a_cnt_clr: assert property (p_cnt_clr)
        else $error("error count not cleared by read");

endmodule : pecs_err_counter

// file: hdl/pecs_regs.sv
// extended control and status register bank behind an apb slave
//
// Behaviour
// - crossover mode 00 straight, 01 crossed, 11 automatic; resets to automatic
// - a written crossover mode only applies after a software reset
// - speed 10 means gigabit, duplex 1 full 0 half; valid once resolved
// - page received latches high; hardware and software reset clear it
// - resolved flag set when negotiation done or disabled, else zero
// - crossover status 1 when pairs A/B and C/D swapped; valid once resolved
// - two bits report attached controller transmit and receive pause ability
// - polarity bit set when any pair has reversed conductors
// - jabber bit follows copper jabber; zero on hardware reset
// - no idles for 1 ms drops lock, takes link down, sets loss bit
// - serial negotiation enable resets to 1; change applies after soft reset
// - sixteen bit counter counts copper receive errors; resets to zero
// - receive error counter saturates at all ones
//
// Our own choice: register access over APB.
module pecs_regs #(
    parameter int unsigned IDLE_LOSS_CYC = pecs_pkg::IDLE_LOSS_CYC
) (
    // clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       rst_i,
    // register bus
    input  wire pecs_pkg::pecs_apb_req_type apb_i,
    output pecs_pkg::pecs_apb_rsp_type      apb_o,
    // physical layer status
    input  wire pecs_pkg::pecs_phy_in_type  phy_i,
    // applied controls
    output logic [1:0]                      mdi_mode_o,
    output logic                            serdes_an_en_o,
    output logic                            link_down_o,
    // interrupt
    output logic                            irq_o
);

    localparam logic [pecs_pkg::IDLE_CNT_W-1:0] IDLE_LIM =
        pecs_pkg::IDLE_CNT_W'(IDLE_LOSS_CYC - 1);

    pecs_pkg::pecs_state_type s_reg;
    pecs_pkg::pecs_state_type s_next;

    logic                       acc;
    logic                       cap;
    logic                       wr;
    logic                       rd;
    logic                       rd_stat1;
    logic                       res;
    logic                       mapped;
    logic                       cnt_clr;
    logic                       loss_next;
    logic [15:0]                rd_word;
    logic [15:0]                st;
    logic [15:0]                err_count;
    logic                       err_sat;
    logic [pecs_pkg::IRQ_W-1:0] ev;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic hit(
        input logic [pecs_pkg::ADDR_W-1:0] a,
        input logic [7:0]                  idx
    );
        return a == {2'b00, idx, 2'b00};
    endfunction : hit

    // one wait state: capture on the first access edge, finish on the next
    assign acc      = apb_i.psel & apb_i.penable;
    assign cap      = acc & ~s_reg.rsp.pready;
    assign wr       = acc & s_reg.rsp.pready & apb_i.pwrite
                      & ~s_reg.rsp.pslverr;
    assign rd       = cap & ~apb_i.pwrite;
    assign rd_stat1 = rd & hit(apb_i.paddr, pecs_pkg::IDX_STAT1);
    assign cnt_clr  = (rd & hit(apb_i.paddr, pecs_pkg::IDX_RXERR))
                      | s_reg.swrst;
    assign res      = phy_i.an_done | phy_i.an_off;

    always_comb begin
        rd_word = 16'h0000;
        mapped  = 1'b1;
        if (hit(apb_i.paddr, pecs_pkg::IDX_CTRL1)) begin
            rd_word = s_reg.ctrl1;
        end else if (hit(apb_i.paddr, pecs_pkg::IDX_STAT1)) begin
            rd_word = s_reg.stat1;
        end else if (hit(apb_i.paddr, pecs_pkg::IDX_CTRL2)) begin
            rd_word = s_reg.ctrl2;
            rd_word[pecs_pkg::LOSS_BIT] = s_reg.loss;
        end else if (hit(apb_i.paddr, pecs_pkg::IDX_RXERR)) begin
            rd_word = err_count;
        end else if (hit(apb_i.paddr, pecs_pkg::IDX_IRQ_STAT)) begin
            rd_word = {12'h000, s_reg.irq_stat};
        end else if (hit(apb_i.paddr, pecs_pkg::IDX_IRQ_MASK)) begin
            rd_word = {12'h000, s_reg.irq_mask};
        end else if (hit(apb_i.paddr, pecs_pkg::IDX_SWRST)) begin
            rd_word = 16'h0000;
        end else begin
            mapped = 1'b0;
        end
    end

    // ************************************************************
    // live status image
    // ************************************************************
    always_comb begin
        st = 16'h0000;
        // speed and duplex hold their last resolved value
        st[pecs_pkg::SPD_LSB +: 2] = res ? phy_i.speed
            : s_reg.stat1[pecs_pkg::SPD_LSB +: 2];
        st[pecs_pkg::DUP_BIT] = res ? phy_i.duplex
            : s_reg.stat1[pecs_pkg::DUP_BIT];
        st[pecs_pkg::PAGE_BIT] = phy_i.page
            | (s_reg.stat1[pecs_pkg::PAGE_BIT] & ~rd_stat1);
        st[pecs_pkg::RES_BIT] = res;
        st[pecs_pkg::LINK_BIT] = phy_i.link & ~loss_next;
        st[pecs_pkg::CLEN_LSB +: 3] = phy_i.cable_len;
        st[pecs_pkg::XOV_BIT] = res & phy_i.xover;
        st[pecs_pkg::TXP_BIT] = res & phy_i.tx_pause;
        st[pecs_pkg::RXP_BIT] = res & phy_i.rx_pause;
        st[pecs_pkg::POL_BIT] = phy_i.polarity;
        st[pecs_pkg::JAB_BIT] = phy_i.jabber;
    end

    // ************************************************************
    // idle watchdog
    // ************************************************************
    // loss stays until idles come back or a soft reset; a dead link has no lock to lose
    assign loss_next = ~s_reg.swrst & phy_i.link & ~phy_i.idle_seen
                       & (s_reg.loss | (s_reg.idle_cnt == IDLE_LIM));

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.swrst = 1'b0;

        // bus answer
        s_next.rsp.pready = cap;
        if (cap) begin
            s_next.rsp.pslverr = ~mapped;
            s_next.rsp.prdata  = {16'h0000, rd_word};
        end

        // status
        s_next.stat1 = st;
        s_next.loss  = loss_next;
        if (!phy_i.link || phy_i.idle_seen) begin
            s_next.idle_cnt = '0;
        end else if (s_reg.idle_cnt != IDLE_LIM) begin
            s_next.idle_cnt = s_reg.idle_cnt + 1'b1;
        end
        s_next.jab_d = phy_i.jabber;
        s_next.sat_d = err_sat;

        // register writes
        if (wr && hit(apb_i.paddr, pecs_pkg::IDX_CTRL1)) begin
            s_next.ctrl1 = apb_i.pwdata[15:0];
        end
        if (wr && hit(apb_i.paddr, pecs_pkg::IDX_CTRL2)) begin
            s_next.ctrl2 = apb_i.pwdata[15:0]
                           & pecs_pkg::CTRL2_WMASK;
        end
        if (wr && hit(apb_i.paddr, pecs_pkg::IDX_IRQ_MASK)) begin
            s_next.irq_mask = apb_i.pwdata[pecs_pkg::IRQ_W-1:0];
        end
        if (wr && hit(apb_i.paddr, pecs_pkg::IDX_IRQ_STAT)) begin
            s_next.irq_stat = s_reg.irq_stat
                              & ~apb_i.pwdata[pecs_pkg::IRQ_W-1:0];
        end
        if (wr && hit(apb_i.paddr, pecs_pkg::IDX_SWRST)) begin
            s_next.swrst = apb_i.pwdata[pecs_pkg::SWRST_BIT];
        end

        // soft reset: pending modes become live, status restarts
        if (s_reg.swrst) begin
            s_next.mdi_eff   = s_reg.ctrl1[pecs_pkg::MDI_LSB +: 2];
            s_next.an_en_eff = s_reg.ctrl2[pecs_pkg::AN_EN_BIT];
            s_next.ctrl2     = s_reg.ctrl2 & ~pecs_pkg::CTRL2_SWCLR;
            s_next.stat1     = {s_reg.stat1[15:13], 13'h0000};
            s_next.idle_cnt  = '0;
        end

        // events set after the clear, so a same-cycle event is kept
        s_next.irq_stat = s_next.irq_stat | ev;
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    end

    always_comb begin
        ev = '0;
        ev[pecs_pkg::IRQ_PAGE] = phy_i.page;
        ev[pecs_pkg::IRQ_LOSS] = loss_next & ~s_reg.loss;
        ev[pecs_pkg::IRQ_JAB]  = phy_i.jabber & ~s_reg.jab_d;
        ev[pecs_pkg::IRQ_SAT]  = err_sat & ~s_reg.sat_d;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_reg <= pecs_pkg::STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // receive error counter
    // ************************************************************
    pecs_err_counter u_err_counter (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .inc_i   (phy_i.rx_err),
        .clr_i   (cnt_clr),
        .count_o (err_count),
        .sat_o   (err_sat)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    assign apb_o          = s_reg.rsp;
    assign mdi_mode_o     = s_reg.mdi_eff;
    assign serdes_an_en_o = s_reg.an_en_eff;
    assign link_down_o    = s_reg.loss;
    assign irq_o          = s_reg.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_acc_start;
        apb_i.psel && apb_i.penable && !apb_o.pready;
    endsequence

    sequence s_sw_pulse;
        s_reg.swrst;
    endsequence

    property p_apb_answer;
        s_acc_start |=> apb_o.pready ##1 !apb_o.pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not one wait state");

    property p_mdi_rst;
        $past(rst_i) |-> mdi_mode_o == pecs_pkg::MDI_AUTO && serdes_an_en_o;
    endproperty
    a_mdi_rst: assert property (p_mdi_rst)
        else $error("controls not at reset value");

    property p_mdi_hold;
        !s_reg.swrst |=> $stable(mdi_mode_o) && $stable(serdes_an_en_o);
    endproperty
    a_mdi_hold: assert property (p_mdi_hold)
        else $error("mode changed without soft reset");

    property p_sw_apply;
        s_sw_pulse |=> mdi_mode_o == $past(s_reg.ctrl1[6:5])
            && serdes_an_en_o == $past(s_reg.ctrl2[3]);
    endproperty
    a_sw_apply: assert property (p_sw_apply)
        else $error("soft reset did not apply modes");

    property p_resolved;
        !s_reg.swrst |=> s_reg.stat1[pecs_pkg::RES_BIT]
            == $past(phy_i.an_done | phy_i.an_off);
    endproperty
    a_resolved: assert property (p_resolved)
        else $error("resolved flag wrong");

    property p_page_set;
        phy_i.page && !s_reg.swrst |=> s_reg.stat1[pecs_pkg::PAGE_BIT];
    endproperty
    a_page_set: assert property (p_page_set)
        else $error("page bit not latched");

    property p_page_clr;
        rd_stat1 && !phy_i.page |=> !s_reg.stat1[pecs_pkg::PAGE_BIT];
    endproperty
    a_page_clr: assert property (p_page_clr)
        else $error("page bit not cleared by read");

    property p_loss;
        s_reg.idle_cnt == IDLE_LIM && phy_i.link && !phy_i.idle_seen
            && !s_reg.swrst |=> link_down_o
            && !s_reg.stat1[pecs_pkg::LINK_BIT];
    endproperty
    a_loss: assert property (p_loss)
        else $error("link not dropped after idle timeout");

    property p_idle_ok;
        phy_i.idle_seen |=> !link_down_o ##1 s_reg.idle_cnt <= 17'h00001;
    endproperty
    a_idle_ok: assert property (p_idle_ok)
        else $error("idle did not restart watchdog");

    property p_jab_pol;
        !s_reg.swrst |=> s_reg.stat1[1:0]
            == {$past(phy_i.polarity), $past(phy_i.jabber)};
    endproperty
    a_jab_pol: assert property (p_jab_pol)
        else $error("polarity or jabber bit wrong");

    property p_speed;
        res && !s_reg.swrst |=> s_reg.stat1[15:13]
            == {$past(phy_i.speed), $past(phy_i.duplex)};
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed or duplex not captured");

endmodule : pecs_regs

// file: tb/pecs_host.sv
// management host model: single apb transfers and read-modify-write
module pecs_host (
    // clock
    input  wire logic                       clock_i,
    // register bus
    output pecs_pkg::pecs_apb_req_type      apb_o,
    input  wire pecs_pkg::pecs_apb_rsp_type apb_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial apb_o = '0;

    // a leading edge keeps psel from being lowered and raised at once
    task automatic xfer(input logic w, input logic [7:0] idx,
        input logic [15:0] d, output logic [15:0] q, output logic e);
        int n;
        n = 0;
        q = 'x;
        e = 1'bx;
        @(posedge clock_i);
        apb_o.paddr   <= {2'h0, idx, 2'h0};
        apb_o.pwrite  <= w;
        apb_o.pwdata  <= {16'h0, d};
        apb_o.psel    <= 1'b1;
        @(posedge clock_i);
        apb_o.penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (apb_i.pready !== 1'b1 && n < 40);
        if (n < 40) begin
            q = apb_i.prdata[15:0];
            e = apb_i.pslverr;
        end
        // released address and data lines must not keep showing the last value
        apb_o.psel    <= 1'b0;
        apb_o.penable <= 1'b0;
        apb_o.paddr   <= ~apb_o.paddr;
        apb_o.pwdata  <= ~apb_o.pwdata;
    endtask : xfer

    task automatic rmw(input logic [7:0] idx, input logic [15:0] m, v);
        logic [15:0] q;
        logic        e;
        xfer(1'b0, idx, 16'h0, q, e);
        xfer(1'b1, idx, (q & ~m) | (v & m), q, e);
    endtask : rmw
endmodule : pecs_host

// file: tb/phy_extended_control_status_regs_tb.sv
// self-checking bench for the extended control and status register bank
module phy_extended_control_status_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned LOSS = 20;
    typedef struct packed {
        logic [16:0] phy;
        logic [15:0] stat;
    } pecs_row_type;

    logic                       clock_i = 1'b0;
    logic                       rst_i   = 1'b1;
    pecs_pkg::pecs_apb_req_type apb_req;
    pecs_pkg::pecs_apb_rsp_type apb_rsp;
    pecs_pkg::pecs_phy_in_type  phy     = '0;
    logic [1:0]                 mdi_mode;
    logic                       an_en;
    logic                       link_down;
    logic                       irq;
    int                         err_count       = 0;
    int                         samples_checked = 0;
    logic [15:0]                q;
    logic                       e;
    logic [1:0]                 last    = 2'h3;
    logic                       last_an = 1'b1;
    logic [1:0]                 modes [3] = '{2'h0, 2'h1, 2'h3};
    // last row leaves speed held while unresolved
    pecs_row_type rows [3] = '{'{17'h155fe, 16'hadcf},
        '{17'h10a02, 16'h8a00}, '{17'h00476, 16'h8401}};

    always #5 clock_i = ~clock_i;

    pecs_regs #(.IDLE_LOSS_CYC(LOSS)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .apb_i(apb_req),
        .apb_o(apb_rsp), .phy_i(phy), .mdi_mode_o(mdi_mode),
        .serdes_an_en_o(an_en), .link_down_o(link_down), .irq_o(irq));
    pecs_host host (.clock_i(clock_i), .apb_o(apb_req), .apb_i(apb_rsp));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] idx);
        host.xfer(1'b0, idx, 16'h0, q, e);
    endtask : rd
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        host.xfer(1'b1, idx, d, q, e);
    endtask : wr
    task automatic swrst();
        wr(pecs_pkg::IDX_SWRST, 16'h0001);
        repeat (2) @(posedge clock_i);
        #1;
    endtask : swrst
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (90000) @(posedge clock_i);
        err_count++;
        print_verdict();
    end

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(pecs_pkg::IDX_CTRL1);
        chk(q, 16'h0078);
        chk({an_en, mdi_mode}, 3'h7);
        rd(pecs_pkg::IDX_CTRL2);
        chk(q, 16'h0c68);
        rd(pecs_pkg::IDX_RXERR);
        chk(q, 16'h0000);
        rd(pecs_pkg::IDX_STAT1);
        chk(q, 16'h0000);
        rd(8'h00);
        chk({e, q}, 17'h10000);
        $display("test reset done");
        foreach (rows[i]) begin
            phy <= pecs_pkg::pecs_phy_in_type'(rows[i].phy);
            repeat (3) @(posedge clock_i);
            rd(pecs_pkg::IDX_STAT1);
            chk(q, rows[i].stat);
        end
        $display("test status rows done");
        foreach (modes[i]) begin
            host.rmw(pecs_pkg::IDX_CTRL1, 16'h0060, {9'h0, modes[i], 5'h0});
            host.rmw(pecs_pkg::IDX_CTRL2, 16'h0008,
                {12'h0, modes[i][0], 3'h0});
            chk({an_en, mdi_mode}, {last_an, last});
            swrst();
            chk({an_en, mdi_mode}, {modes[i][0], modes[i]});
            rd(pecs_pkg::IDX_CTRL1);
            chk(q, {9'h0, modes[i], 5'h18});
            last = modes[i];
            last_an = modes[i][0];
        end
        $display("test crossover and negotiation done");
        phy.page <= 1'b1;
        @(posedge clock_i);
        phy.page <= 1'b0;
        rd(pecs_pkg::IDX_STAT1);
        chk(q[12], 1'b1);
        rd(pecs_pkg::IDX_STAT1);
        chk(q[12], 1'b0);
        chk(irq, 1'b0);
        wr(pecs_pkg::IDX_IRQ_MASK, 16'h0001);
        repeat (2) @(posedge clock_i);
        chk(irq, 1'b1);
        wr(pecs_pkg::IDX_IRQ_STAT, 16'h0001);
        repeat (2) @(posedge clock_i);
        chk(irq, 1'b0);
        phy.page <= 1'b1;
        @(posedge clock_i);
        phy.page <= 1'b0;
        swrst();
        rd(pecs_pkg::IDX_STAT1);
        chk(q[12], 1'b0);
        $display("test page and interrupt done");
        phy.rx_err <= 1'b1;
        repeat (5) @(posedge clock_i);
        phy.rx_err <= 1'b0;
        rd(pecs_pkg::IDX_RXERR);
        chk(q, 16'h0005);
        rd(pecs_pkg::IDX_RXERR);
        chk(q, 16'h0000);
        phy.rx_err <= 1'b1;
        repeat (65540) @(posedge clock_i);
        phy.rx_err <= 1'b0;
        rd(pecs_pkg::IDX_RXERR);
        chk(q, 16'hffff);
        rd(pecs_pkg::IDX_IRQ_STAT);
        chk(q[3], 1'b1);
        $display("test error counter done");
        phy.link <= 1'b1;
        phy.idle_seen <= 1'b0;
        repeat (LOSS - 2) @(posedge clock_i);
        chk(link_down, 1'b0);
        repeat (4) @(posedge clock_i);
        chk(link_down, 1'b1);
        rd(pecs_pkg::IDX_CTRL2);
        chk(q[15], 1'b1);
        rd(pecs_pkg::IDX_STAT1);
        chk(q[10], 1'b0);
        $display("test idle loss done");
        print_verdict();
    end
endmodule : phy_extended_control_status_regs_tb
